// ---- hdl/ssp_regs.vh ----
// register offsets, field positions and reset values of the serial port
`ifndef SSP_REGS_VH
`define SSP_REGS_VH
`define SSP_OFF_IRQ_EN_A 8'h00
`define SSP_OFF_IRQ_EN_B 8'h04
`define SSP_OFF_IRQ_FLG_A 8'h08
`define SSP_OFF_IRQ_FLG_B 8'h0c
`define SSP_OFF_CTRL 8'h10
`define SSP_OFF_TCTRL 8'h14
`define SSP_OFF_RCTRL 8'h18
`define SSP_OFF_MOD 8'h1c
`define SSP_OFF_DIV_LO 8'h20
`define SSP_OFF_DIV_HI 8'h24
`define SSP_OFF_RXBUF 8'h28
`define SSP_OFF_TXBUF 8'h2c
`define SSP_OFF_ENABLE 8'h30
`define SSP_BIT_TXIE 7
`define SSP_BIT_RXIE 6
`define SSP_BIT_TXIE_B 5
`define SSP_BIT_RXIE_B 4
`define SSP_BIT_SRST 0
`define SSP_BIT_MSTR 1
`define SSP_BIT_SYNC 2
`define SSP_BIT_FOURPIN 3
`define SSP_BIT_CHAR 4
`define SSP_BIT_TWOWIRE 5
`define SSP_BIT_PHASE 7
`define SSP_BIT_IDLE 6
`define SSP_BIT_SSEL_HI 5
`define SSP_BIT_SSEL_LO 4
`define SSP_BIT_TEMPTY 0
`define SSP_BIT_FAULT 7
`define SSP_BIT_OVR 5
`define SSP_BIT_PEN 0
`define SSP_RST_CTRL 8'h01
`define SSP_RST_FLG_A 8'h80
`endif

// ---- hdl/ssp_spi.v ----
// synchronous serial port in peripheral-interface mode with AHB-Lite registers
//
// Summary of operation
// - port works only with sync set, two-wire clear
// - master drives data-out and clock; slave reverse
// - 4-pin master, enable low: release pins, fault
// - 4-pin slave, enable high: halt, release output
// - 3-pin modes ignore bus-enable input
// - soft reset clears enables, flags; tx flag set
// - master: buffer write starts transfer, MSB first
// - sample opposite edge; full char sets rx flag
// - tx flag on buffer move; empty bit ends
// - slave: external clock; preloaded char sent
// - overrun when unread buffer is overwritten
// - enable clear stops after transfer; reset immediate
// - disabled port does not transmit buffer writes
// - disabled port receives only the character in progress
// - master outputs divided clock; slave uses pin
// - bit clock is source over 16-bit divisor
// - per-channel interrupt enables gate their flags
// - tx flag resets to 1, rx flag 0
// - polarity and phase chosen independently
// - phase 0 changes first edge; polarity idle
// - source select picks external, aux, sub-main; external select gives no ticks here
// - tx flag clears on write, rx on read
// - char bit selects 7 or 8 data bits
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "ssp_regs.vh"
module ssp_spi (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire aux_clock_tick,
  input wire sub_main_clock_tick,
  input wire master_out_line_in,
  output reg master_out_line_out,
  output reg master_out_line_oe,
  input wire master_in_line_in,
  output reg master_in_line_out,
  output reg master_in_line_oe,
  input wire serial_bit_clock_pin_in,
  output reg serial_bit_clock_pin_out,
  output reg serial_bit_clock_pin_oe,
  input wire bus_enable_pin_in,
  output reg irq_tx,
  output reg irq_rx
);
  localparam ST_IDLE = 2'd0;
  localparam ST_LOAD = 2'd1;
  localparam ST_SHIFT = 2'd2;

  reg [7:0] serial_irq_enable_a, serial_irq_enable_b, serial_irq_flags_a, serial_irq_flags_b;
  reg [7:0] ctrl, tctrl, mod_reg, div_lo, div_hi, rx_buf, tx_buf;
  reg port_enable, framing_fault, overrun, tx_full;
  reg [1:0] state;
  reg [7:0] tx_shift, rx_shift;
  reg [3:0] bit_cnt;
  reg half;
  reg [15:0] div_cnt;
  reg sclk_int;
  reg [1:0] clk_sync, ste_sync, mi_sync, mo_sync;
  reg clk_prev;
  reg ph_wr, ph_rd;
  reg [7:0] ph_addr;

  wire soft_reset_hold = ctrl[`SSP_BIT_SRST];
  wire master_select = ctrl[`SSP_BIT_MSTR];
  wire four_pin = ctrl[`SSP_BIT_FOURPIN];
  wire char8 = ctrl[`SSP_BIT_CHAR];
  wire spi_mode = ctrl[`SSP_BIT_SYNC] & ~ctrl[`SSP_BIT_TWOWIRE];
  wire clock_edge_phase = tctrl[`SSP_BIT_PHASE];
  wire clock_idle_level = tctrl[`SSP_BIT_IDLE];
  wire [1:0] source_clock_select = tctrl[`SSP_BIT_SSEL_HI:`SSP_BIT_SSEL_LO];
  wire [15:0] divisor = {div_hi, div_lo};
  wire tx_irq_flag = serial_irq_flags_a[`SSP_BIT_TXIE];
  wire rx_irq_flag = serial_irq_flags_a[`SSP_BIT_RXIE];
  // bus-enable only used in 4-pin modes
  wire bus_enable_pin = ste_sync[1];
  wire m_block = master_select & four_pin & ~bus_enable_pin;
  wire s_block = ~master_select & four_pin & bus_enable_pin;
  // source select decode; external source never runs the divider
  wire src_tick = (source_clock_select == 2'b01) ? aux_clock_tick :
                  (source_clock_select[1] ? sub_main_clock_tick : 1'b0);
  wire [3:0] nbits = char8 ? 4'd8 : 4'd7;
  wire run_ok = spi_mode & ~soft_reset_hold;
  // slave edges from synchronised pin, master from own divider
  wire ext_edge = clk_sync[1] ^ clk_prev;
  wire ext_first = (clk_sync[1] != clock_idle_level);
  reg edge_now, edge_lead;
  reg [15:0] next_div_cnt;

  always @*
  begin
    next_div_cnt = div_cnt;
    edge_now = 1'b0;
    edge_lead = 1'b0;
    if (master_select)
    begin
      if (state == ST_SHIFT && src_tick)
      begin
        // two half-periods make one divisor of source ticks
        if (div_cnt >= divisor - 16'd1)
          next_div_cnt = 16'd0;
        else
          next_div_cnt = div_cnt + 16'd1;
        edge_now = (div_cnt == 16'd0) | (div_cnt == {1'b0, divisor[15:1]});
        edge_lead = (div_cnt == 16'd0);
      end
    end
    else
    begin
      edge_now = ext_edge;
      edge_lead = ext_first;
    end
  end

  // capture edge is the leading one when phase is 1
  wire cap_edge = edge_now & (edge_lead == clock_edge_phase);
  wire chg_edge = edge_now & (edge_lead != clock_edge_phase);
  wire data_in = master_select ? mi_sync[1] : mo_sync[1];
  wire [7:0] rx_char = char8 ? rx_shift : {1'b0, rx_shift[6:0]};

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clk_sync <= 2'b00;
      ste_sync <= 2'b11;
      mi_sync <= 2'b00;
      mo_sync <= 2'b00;
      clk_prev <= 1'b0;
    end
    else
    begin
      clk_sync <= {clk_sync[0], serial_bit_clock_pin_in};
      ste_sync <= {ste_sync[0], bus_enable_pin_in | ~four_pin};
      mi_sync <= {mi_sync[0], master_in_line_in};
      mo_sync <= {mo_sync[0], master_out_line_in};
      clk_prev <= clk_sync[1];
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_addr <= 8'h00;
    end
    else
    begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      if (hsel && hready && htrans[1])
      begin
        ph_wr <= hwrite;
        ph_rd <= ~hwrite;
        ph_addr <= haddr[7:0];
        case (haddr[7:0])
          `SSP_OFF_IRQ_EN_A: hrdata <= {24'h0, serial_irq_enable_a};
          `SSP_OFF_IRQ_EN_B: hrdata <= {24'h0, serial_irq_enable_b};
          `SSP_OFF_IRQ_FLG_A: hrdata <= {24'h0, serial_irq_flags_a};
          `SSP_OFF_IRQ_FLG_B: hrdata <= {24'h0, serial_irq_flags_b};
          `SSP_OFF_CTRL: hrdata <= {24'h0, ctrl};
          `SSP_OFF_TCTRL: hrdata <= {24'h0, tctrl[7:1], state == ST_IDLE && !tx_full};
          `SSP_OFF_RCTRL: hrdata <= {24'h0, framing_fault, 1'b0, overrun, 5'h00};
          `SSP_OFF_MOD: hrdata <= {24'h0, mod_reg};
          `SSP_OFF_DIV_LO: hrdata <= {24'h0, div_lo};
          `SSP_OFF_DIV_HI: hrdata <= {24'h0, div_hi};
          `SSP_OFF_RXBUF: hrdata <= {24'h0, rx_buf};
          `SSP_OFF_TXBUF: hrdata <= {24'h0, tx_buf};
          `SSP_OFF_ENABLE: hrdata <= {31'h0, port_enable};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  wire wr_txbuf = ph_wr && ph_addr == `SSP_OFF_TXBUF;
  wire rd_rxbuf = ph_rd && ph_addr == `SSP_OFF_RXBUF;
  wire [7:0] wd = hwdata[7:0];
  // character ends once all bits are in and the clock is back at its idle level
  wire clk_at_idle = master_select ? ~sclk_int : (clk_sync[1] == clock_idle_level);
  wire rx_done = (state == ST_SHIFT) && (bit_cnt == nbits) && clk_at_idle;
  wire load_now = (state == ST_LOAD);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= `SSP_RST_CTRL;
      tctrl <= 8'h00;
      mod_reg <= 8'h00;
      div_lo <= 8'h00;
      div_hi <= 8'h00;
      tx_buf <= 8'h00;
      rx_buf <= 8'h00;
      port_enable <= 1'b0;
      serial_irq_enable_a <= 8'h00;
      serial_irq_enable_b <= 8'h00;
      serial_irq_flags_a <= `SSP_RST_FLG_A;
      serial_irq_flags_b <= 8'h00;
      framing_fault <= 1'b0;
      overrun <= 1'b0;
      tx_full <= 1'b0;
      state <= ST_IDLE;
      tx_shift <= 8'h00;
      rx_shift <= 8'h00;
      bit_cnt <= 4'd0;
      half <= 1'b0;
      div_cnt <= 16'd0;
      sclk_int <= 1'b0;
      irq_tx <= 1'b0;
      irq_rx <= 1'b0;
      master_out_line_out <= 1'b0;
      master_out_line_oe <= 1'b0;
      master_in_line_out <= 1'b0;
      master_in_line_oe <= 1'b0;
      serial_bit_clock_pin_out <= 1'b0;
      serial_bit_clock_pin_oe <= 1'b0;
    end
    else
    begin
      if (ph_wr)
      begin
        case (ph_addr)
          `SSP_OFF_IRQ_EN_A: serial_irq_enable_a <= wd;
          `SSP_OFF_IRQ_EN_B: serial_irq_enable_b <= wd;
          `SSP_OFF_IRQ_FLG_A: serial_irq_flags_a <= wd;
          `SSP_OFF_IRQ_FLG_B: serial_irq_flags_b <= wd;
          `SSP_OFF_CTRL: ctrl <= wd;
          `SSP_OFF_TCTRL: tctrl <= {wd[7:1], 1'b0};
          `SSP_OFF_RCTRL:
          begin
            framing_fault <= wd[`SSP_BIT_FAULT];
            overrun <= wd[`SSP_BIT_OVR];
          end
          `SSP_OFF_MOD: mod_reg <= wd;
          `SSP_OFF_DIV_LO: div_lo <= wd;
          `SSP_OFF_DIV_HI: div_hi <= wd;
          `SSP_OFF_TXBUF:
          begin
            // unused top bit cleared in 7-bit mode
            tx_buf <= char8 ? wd : {1'b0, wd[6:0]};
            tx_full <= 1'b1;
          end
          `SSP_OFF_ENABLE: port_enable <= wd[`SSP_BIT_PEN];
          default: ;
        endcase
      end
      if (wr_txbuf)
        serial_irq_flags_a[`SSP_BIT_TXIE] <= 1'b0;
      if (rd_rxbuf)
        serial_irq_flags_a[`SSP_BIT_RXIE] <= 1'b0;
      if (m_block && spi_mode)
        framing_fault <= 1'b1;
      case (state)
        ST_IDLE:
        begin
          div_cnt <= 16'd0;
          bit_cnt <= 4'd0;
          if (run_ok && port_enable && tx_full && !m_block)
            state <= ST_LOAD;
        end
        ST_LOAD:
        begin
          tx_shift <= tx_buf;
          tx_full <= 1'b0;
          state <= ST_SHIFT;
        end
        ST_SHIFT:
        begin
          div_cnt <= next_div_cnt;
          if (edge_now && master_select)
            sclk_int <= ~sclk_int;
          // capture only when bus enable does not block and the character is not yet complete
          if (cap_edge && !s_block && !m_block && bit_cnt != nbits)
          begin
            rx_shift <= {rx_shift[6:0], data_in};
            bit_cnt <= bit_cnt + 4'd1;
          end
          // phase 0: the first change edge presents the MSB already on the line
          if (chg_edge && !s_block && (bit_cnt != 4'd0 || clock_edge_phase))
            tx_shift <= {tx_shift[6:0], 1'b0};
          // halted slave drops the partial character
          if (s_block)
            bit_cnt <= 4'd0;
          if (rx_done)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      // slave idles in shift waiting for the external clock
      if (state == ST_IDLE && !master_select && run_ok && port_enable && !tx_full && !s_block)
        state <= ST_SHIFT;
      if (rx_done)
      begin
        rx_buf <= rx_char;
        if (rx_irq_flag && !rd_rxbuf)
          overrun <= 1'b1;
        // receive flag set wins over clear
        serial_irq_flags_a[`SSP_BIT_RXIE] <= 1'b1;
      end
      // tx flag set when buffer moves, set wins
      if (load_now)
        serial_irq_flags_a[`SSP_BIT_TXIE] <= 1'b1;
      // slave enable drop stops only when idle
      if (!port_enable && state == ST_SHIFT && bit_cnt == 4'd0 && !master_select)
        state <= ST_IDLE;
      // soft reset clears and stops immediately
      if (soft_reset_hold)
      begin
        state <= ST_IDLE;
        tx_full <= 1'b0;
        sclk_int <= 1'b0;
        serial_irq_enable_a[`SSP_BIT_TXIE] <= 1'b0;
        serial_irq_enable_a[`SSP_BIT_RXIE] <= 1'b0;
        serial_irq_flags_a[`SSP_BIT_TXIE] <= 1'b1;
        serial_irq_flags_a[`SSP_BIT_RXIE] <= 1'b0;
        overrun <= 1'b0;
        framing_fault <= 1'b0;
      end
      irq_tx <= serial_irq_enable_a[`SSP_BIT_TXIE] & tx_irq_flag;
      irq_rx <= serial_irq_enable_a[`SSP_BIT_RXIE] & rx_irq_flag;
      master_out_line_oe <= spi_mode & master_select & ~m_block;
      serial_bit_clock_pin_oe <= spi_mode & master_select & ~m_block;
      master_in_line_oe <= spi_mode & ~master_select & ~s_block;
      master_out_line_out <= tx_shift[7];
      master_in_line_out <= tx_shift[7];
      // polarity applied to the generated clock
      serial_bit_clock_pin_out <= sclk_int ^ clock_idle_level;
    end
  end
endmodule // ssp_spi

// ---- testbench/ssp_spi_checker.sv ----
// concurrent checks on the serial port top-level ports
`timescale 1ns/1ps
module ssp_spi_checker (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire master_out_line_oe,
  input wire master_in_line_oe,
  input wire serial_bit_clock_pin_oe,
  input wire bus_enable_pin_in,
  input wire irq_tx,
  input wire irq_rx
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_take;
    hsel && hready && htrans[1];
  endsequence
  sequence s_read;
    s_take ##0 !hwrite;
  endsequence
  a_read_upper:
    assert property (s_read |=> hrdata[31:8] == 24'h0) else $error("upper read bits set");
  a_read_hold:
    assert property (!(hsel && hready && htrans[1]) |=> $stable(hrdata))
      else $error("read data moved without access");
  a_bus_okay:
    assert property (hreadyout && !hresp) else $error("bus not ready or error");
  a_pins_pair:
    assert property (serial_bit_clock_pin_oe == master_out_line_oe) else $error("clock and data oe split");
  a_pins_excl:
    assert property (!(master_out_line_oe && master_in_line_oe)) else $error("both data lines driven");
  a_slave_no_clk:
    assert property (master_in_line_oe |-> !serial_bit_clock_pin_oe) else $error("slave drives clock");
  a_drive_sync:
    assert property ($rose(master_out_line_oe) |-> $past(bus_enable_pin_in, 2))
      else $error("pin driven before enable synchronised");
  a_reset_quiet:
    assert property ($rose(hresetn) |-> (!irq_tx && !irq_rx) [*2]) else $error("irq after reset");
endmodule // ssp_spi_checker
bind ssp_spi ssp_spi_checker ssp_spi_checker_inst (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hrdata, .hreadyout, .hresp, .master_out_line_oe, .master_in_line_oe,
  .serial_bit_clock_pin_oe, .bus_enable_pin_in, .irq_tx, .irq_rx);

// ---- testbench/ssp_slave_model.sv ----
// external slave on the serial lines: shifts one byte out, captures one in
`timescale 1ns/1ps
module ssp_slave_model (
  input wire sclk,
  input wire mosi,
  input wire idle_high,
  input wire cap_first,
  input wire load,
  input wire [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte,
  output int edges
);
  logic [7:0] sh;
  int idx;
  initial
  begin
    edges = 0;
    idx = 9;
    rx_byte = 8'h0;
    sh = 8'h0;
  end
  always @(sclk or posedge load)
    if (load)
    begin
      sh = tx_byte;
      idx = cap_first ? 0 : -1;
      edges = 0;
    end
    else
    begin
      edges++;
      if ((sclk !== idle_high) == cap_first) rx_byte = {rx_byte[6:0], mosi};
      else idx++;
    end
  // released line toggles instead of holding
  assign miso = (idx >= 0 && idx < 8) ? sh[7 - idx] : edges[0];
endmodule // ssp_slave_model

// ---- testbench/ssp_spi_test.sv ----
// self-checking bench for the serial port against an external slave model
`timescale 1ns/1ps
`include "ssp_regs.vh"
module ssp_spi_test;
  logic hclk, hresetn, hsel, hwrite, aux_tick, sub_tick, bus_en, sclk_drv, ld, pol, ph;
  logic [31:0] haddr, hwdata, lf, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] tx_b, t;
  wire [31:0] hrdata;
  wire [7:0] rx_b;
  wire hreadyout, hresp, mo_out, mo_oe, mi_out, mi_oe, ck_out, ck_oe, irq_tx, irq_rx, miso;
  wire mo = mo_oe ? mo_out : lf[3];
  wire mi = mi_oe ? mi_out : miso;
  wire ck = ck_oe ? ck_out : sclk_drv;
  int miscompares, compares, edges;
  logic [7:0] exp_q[$];
  ssp_spi ssp_spi_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .aux_clock_tick(aux_tick),
    .sub_main_clock_tick(sub_tick), .master_out_line_in(mo), .master_out_line_out(mo_out),
    .master_out_line_oe(mo_oe), .master_in_line_in(mi), .master_in_line_out(mi_out),
    .master_in_line_oe(mi_oe), .serial_bit_clock_pin_in(ck), .serial_bit_clock_pin_out(ck_out),
    .serial_bit_clock_pin_oe(ck_oe), .bus_enable_pin_in(bus_en), .irq_tx(irq_tx),
    .irq_rx(irq_rx));
  ssp_slave_model ssp_slave_model_inst (.sclk(ck), .mosi(mo), .idle_high(pol),
    .cap_first(ph), .load(ld), .tx_byte(tx_b), .miso(miso), .rx_byte(rx_b), .edges(edges));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  initial
  begin
    hclk = 0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    lf <= lfsr(lf);
    aux_tick <= lf[0];
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    k = 0;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 50);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    k = 0;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 50);
    rd = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(nm, e, rd);
  endtask
  task automatic cfg(input logic [7:0] c);
    bus(1, `SSP_OFF_CTRL, c | 8'h01);
    bus(1, `SSP_OFF_TCTRL, t);
    // divisor leaves room for the two-flop input synchroniser
    bus(1, `SSP_OFF_DIV_LO, 8'h10);
    bus(1, `SSP_OFF_DIV_HI, 0);
    bus(1, `SSP_OFF_MOD, 0);
    bus(1, `SSP_OFF_ENABLE, 1);
    bus(1, `SSP_OFF_CTRL, c);
    bus(1, `SSP_OFF_IRQ_EN_A, 8'hc0);
  endtask
  task automatic xfer(input logic [7:0] d, input logic [7:0] b);
    int n;
    tx_b <= b;
    ld <= 1;
    @(posedge hclk);
    ld <= 0;
    bus(1, `SSP_OFF_TXBUF, d);
    exp_q.push_back(b);
    n = 0;
    do begin bus(0, `SSP_OFF_TCTRL, 0); n++; end while (rd[0] !== 1'b1 && n < 2000);
    if (n >= 2000) miscompares++;
    bus(0, `SSP_OFF_IRQ_FLG_A, 0);
    chk("flags", 8'hc0, rd);
    chk("slave rx", d, rx_b);
  endtask
  task print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #1000000;
    miscompares++;
    print_verdict;
  end
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, aux_tick, sclk_drv, ld, tx_b, pol, ph} = 0;
    {hsize, sub_tick, bus_en, lf, miscompares, compares} = {3'h2, 2'b11, 32'h32d1, 64'h0};
    repeat (8) @(posedge hclk);
    hresetn <= 1;
    rdchk("ctrl", `SSP_OFF_CTRL, 8'h01);
    rdchk("flg", `SSP_OFF_IRQ_FLG_A, 8'h80);
    rdchk("tctrl", `SSP_OFF_TCTRL, 8'h01);
    bus(1, 8'h40, 32'h5a);
    rdchk("unmapped", 8'h40, 0);
    bus(1, `SSP_OFF_IRQ_EN_A, 8'hc0);
    rdchk("en held", `SSP_OFF_IRQ_EN_A, 0);
    bus(1, `SSP_OFF_IRQ_FLG_A, 8'h40);
    rdchk("flg held", `SSP_OFF_IRQ_FLG_A, 8'h80);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      {pol, ph} = i[1:0];
      sclk_drv <= i[1];
      t = {i[0], i[1], i[0] ? 2'b10 : 2'b01, 4'h0};
      cfg(8'h16);
      xfer(lf[7:0], lf[15:8]);
      chk("oe", 2'b10, {mo_oe, mi_oe});
      chk("irq", 2'b11, {irq_tx, irq_rx});
      rdchk("rxbuf", `SSP_OFF_RXBUF, exp_q.pop_front());
      rdchk("flg", `SSP_OFF_IRQ_FLG_A, 8'h80);
      rdchk("tctrl", `SSP_OFF_TCTRL, t | 8'h01);
    end
    $display("test modes done");
    xfer(8'h81, 8'h7e);
    xfer(8'h01, 8'hfe);
    rdchk("rctrl", `SSP_OFF_RCTRL, 8'h20);
    void'(exp_q.pop_front());
    rdchk("rxbuf", `SSP_OFF_RXBUF, exp_q.pop_front());
    bus(1, `SSP_OFF_ENABLE, 0);
    ld <= 1;
    @(posedge hclk);
    ld <= 0;
    bus(1, `SSP_OFF_TXBUF, 8'h5a);
    repeat (100) @(posedge hclk);
    chk("edges", 0, edges);
    $display("test disable done");
    cfg(8'h1e);
    bus_en <= 0;
    repeat (10) @(posedge hclk);
    chk("oe low", 2'b00, {mo_oe, ck_oe});
    rdchk("fault", `SSP_OFF_RCTRL, 8'h80);
    bus_en <= 1;
    repeat (10) @(posedge hclk);
    chk("oe back", 2'b11, {mo_oe, ck_oe});
    $display("test bus enable done");
    print_verdict;
  end
endmodule // ssp_spi_test
